/* File: rtl/ism_pkg.sv */
// constants, widths and state codes for the serial memory target
// assumes a 13-bit byte-addressed array behind a two-wire target port
package ism_pkg;

    localparam int ADDR_W      = 13;
    localparam int DATA_W      = 8;
    localparam int MEM_DEPTH   = 8192;
    localparam int CNT_W       = 4;
    localparam int HI_W        = 5;
    localparam int SYNC_STAGES = 2;

    // bits per byte on the wire, and the bit counter's cleared value
    localparam logic [CNT_W-1:0]  BYTE_BITS = 4'h8;
    localparam logic [CNT_W-1:0]  CNT_ZERO  = 4'h0;

    // address latch bounds
    localparam logic [ADDR_W-1:0] ADDR_TOP  = 13'h1fff;
    localparam logic [ADDR_W-1:0] ADDR_BASE = 13'h0000;
    localparam logic [ADDR_W-1:0] ADDR_ONE  = 13'h0001;

    // device type code in target address bits 7..4; value is arbitrary
    localparam logic [3:0] DEV_TYPE = 4'h5;

    // target address field positions
    localparam int TYPE_LSB = 4;
    localparam int SEL_MSB  = 3;
    localparam int SEL_LSB  = 1;
    localparam int DIR_POS  = 0;

    // direction bit: 1 reads, 0 writes
    localparam logic DIR_READ = 1'b1;

    // open-drain pin only ever pulls low
    localparam logic SDA_LOW = 1'b0;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_DEV,
        ST_ACK_DEV,
        ST_ADR_HI,
        ST_ACK_HI,
        ST_ADR_LO,
        ST_ACK_LO,
        ST_WDATA,
        ST_ACK_WR,
        ST_WR_REFUSE,
        ST_RDATA,
        ST_ACK_RD
    } ism_state_t;

endpackage

/* File: rtl/ism_mem_if.sv */
// memory port between the bus engine and the storage array
// assumes one write or read address per system clock
`timescale 1ns/1ps
interface ism_mem_if;
    import ism_pkg::*;

    logic              wr_en;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;

    modport ctrl  (output wr_en, output addr, output wdata, input rdata);
    modport store (input wr_en, input addr, input wdata, output rdata);
endinterface

/* File: rtl/ism_sync.sv */
// two-flop synchroniser for a vector of asynchronous levels
// assumes each bit is an independent level from outside the clock domain
// resets to ones, the idle level of the bus lines
`timescale 1ns/1ps
module ism_sync
    import ism_pkg::*;
#(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // levels
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta_r;

    always_ff @(posedge clk) begin
        if (rst) begin
            meta_r <= '1;
            q      <= '1;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end

endmodule // ism_sync

/* File: rtl/ism_mem.sv */
// byte-wide storage array with a registered read
// assumes write data and address are stable in the write-enable cycle
`timescale 1ns/1ps
module ism_mem
    import ism_pkg::*;
(
    // clock
    input  wire logic clk,
    // memory port
    ism_mem_if.store  port
);

    logic [DATA_W-1:0] array_r [MEM_DEPTH];

    // store one byte; done within the same system clock
    always_ff @(posedge clk) begin
        if (port.wr_en) begin
            array_r[port.addr] <= port.wdata;
        end
    end

    // read follows the address every cycle
    always_ff @(posedge clk) begin
        port.rdata <= array_r[port.addr];
    end

endmodule // ism_mem

/* File: rtl/ism_top.sv */
// two-wire target engine for an 8K x 8 byte-addressed memory
// assumes SCL, SDA, WP and select inputs are asynchronous to CLK_SYS,
// and SCL high and low phases each last several system clocks
//
// What this block does
// - write is target address with direction 0, two address bytes, then acked data
// - any number of write bytes; address counter wraps 1fff to 0000
// - no write delay; target address is always acked when it matches
// - each data byte is stored at the 8th bit, on the same system clock edge that starts the ack drive
// - start or stop before the 8th bit discards the partial byte
// - write-protect high refuses data bytes with no acknowledge
// - refused data byte leaves the address counter unchanged
// - write-protect low unprotects
// - direction 1 starts driving data from the latch on the next clock
// - read increments address per byte; controller ack requests next byte
// - read address wraps from 1fff to 0000
// - an acked last byte makes the device keep driving further data
// - random read: write header and address, then start and read header
// - respond only to matching device type and select address bits
// - address arrives in two bytes; 13 bits kept, top three ignored
// - address latch increments after each stored or read data byte, before the ack
// - all bytes shift most significant bit first
`timescale 1ns/1ps
module ism_top
    import ism_pkg::*;
(
    // system clock and reset
    input  wire logic              CLK_SYS,
    input  wire logic              RESET,
    // two-wire bus
    input  wire logic              SCL,
    input  wire logic              SDA,
    output logic                   SDA_DRV,
    output logic                   SDA_OE,
    // straps and protection
    input  wire logic              WP,
    input  wire logic [2:0]        SELECT_ADDRESS_INPUTS,
    // status
    output logic [ADDR_W-1:0]      ADDR_CURRENT,
    output logic                   BUSY
);

    // synchronised inputs
    logic [5:0]        sync_q;
    logic              scl_s;
    logic              sda_s;
    logic              wp_s;
    logic [2:0]        sel_s;
    logic              scl_d_r;
    logic              sda_d_r;

    // bus events
    logic              scl_rise;
    logic              scl_fall;
    logic              bus_start;
    logic              bus_stop;

    // engine state
    ism_state_t        state_r;
    ism_state_t        state_nxt;
    logic [CNT_W-1:0]  cnt_r;
    logic [DATA_W-1:0] rx_r;
    logic [DATA_W-1:0] tx_r;
    logic [HI_W-1:0]   hi_r;
    logic [ADDR_W-1:0] addr_r;
    logic              oe_r;
    logic              oe_nxt;

    // decoded conditions
    logic              byte_done;
    logic              dev_match;
    logic              rx_state;
    logic              wr_commit;
    logic              rd_load;

    ism_mem_if mem_port ();

    function automatic logic [ADDR_W-1:0] addr_inc(input logic [ADDR_W-1:0] a);
        if (a == ADDR_TOP) begin
            return ADDR_BASE;
        end else begin
            return a + ADDR_ONE;
        end
    endfunction

    // two flops on every outside input except RESET
    ism_sync #(
        .W (6)
    ) u_sync (
        .clk (CLK_SYS),
        .rst (RESET),
        .d   ({SCL, SDA, WP, SELECT_ADDRESS_INPUTS}),
        .q   (sync_q)
    );

    assign scl_s = sync_q[5];
    assign sda_s = sync_q[4];
    assign wp_s  = sync_q[3];
    assign sel_s = sync_q[2:0];

    ism_mem u_mem (
        .clk  (CLK_SYS),
        .port (mem_port.store)
    );

    // delayed copies for edge detection; reset to the idle bus level
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            scl_d_r <= scl_s;
            sda_d_r <= sda_s;
        end
    end

    assign scl_rise  = scl_s & ~scl_d_r;
    assign scl_fall  = ~scl_s & scl_d_r;
    assign bus_start = scl_s & scl_d_r & sda_d_r & ~sda_s;
    assign bus_stop  = scl_s & scl_d_r & ~sda_d_r & sda_s;

    assign byte_done = scl_fall & (cnt_r == BYTE_BITS);
    assign dev_match = (rx_r[DATA_W-1:TYPE_LSB] == DEV_TYPE) &&
                       (rx_r[SEL_MSB:SEL_LSB] == sel_s);

    assign rx_state = (state_r == ST_DEV) || (state_r == ST_ADR_HI) ||
                      (state_r == ST_ADR_LO) || (state_r == ST_WDATA);

    // store at the 8th bit unless protected
    assign wr_commit = byte_done & (state_r == ST_WDATA) & ~wp_s;

    // load a byte to send at the end of an ack clock
    assign rd_load = scl_fall &
                     (((state_r == ST_ACK_DEV) && (rx_r[DIR_POS] == DIR_READ)) ||
                      (state_r == ST_ACK_RD));

    // next transaction state
    always_comb begin
        state_nxt = state_r;
        if (bus_start) begin
            state_nxt = ST_DEV;
        end else if (bus_stop) begin
            state_nxt = ST_IDLE;
        end else begin
            unique case (state_r)
                ST_IDLE: begin
                    state_nxt = ST_IDLE;
                end
                ST_DEV: begin
                    if (byte_done) begin
                        state_nxt = dev_match ? ST_ACK_DEV : ST_IDLE;
                    end
                end
                ST_ACK_DEV: begin
                    if (scl_fall) begin
                        if (rx_r[DIR_POS] == DIR_READ) begin
                            state_nxt = ST_RDATA;
                        end else begin
                            state_nxt = ST_ADR_HI;
                        end
                    end
                end
                ST_ADR_HI: begin
                    if (byte_done) begin
                        state_nxt = ST_ACK_HI;
                    end
                end
                ST_ACK_HI: begin
                    if (scl_fall) begin
                        state_nxt = ST_ADR_LO;
                    end
                end
                ST_ADR_LO: begin
                    if (byte_done) begin
                        state_nxt = ST_ACK_LO;
                    end
                end
                ST_ACK_LO: begin
                    if (scl_fall) begin
                        state_nxt = ST_WDATA;
                    end
                end
                ST_WDATA: begin
                    if (byte_done) begin
                        state_nxt = wp_s ? ST_WR_REFUSE : ST_ACK_WR;
                    end
                end
                ST_ACK_WR: begin
                    if (scl_fall) begin
                        state_nxt = ST_WDATA;
                    end
                end
                ST_WR_REFUSE: begin
                    if (scl_fall) begin
                        state_nxt = ST_IDLE;
                    end
                end
                ST_RDATA: begin
                    if (byte_done) begin
                        state_nxt = ST_ACK_RD;
                    end
                end
                ST_ACK_RD: begin
                    if (scl_rise && sda_s) begin
                        state_nxt = ST_IDLE;
                    end else if (scl_fall) begin
                        state_nxt = ST_RDATA;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // bit counter: cleared on conditions and at every byte boundary
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            cnt_r <= CNT_ZERO;
        end else if (bus_start || bus_stop) begin
            cnt_r <= CNT_ZERO;
        end else if (scl_fall && (state_nxt != state_r)) begin
            cnt_r <= CNT_ZERO;
        end else if (scl_rise && (cnt_r != BYTE_BITS)) begin
            cnt_r <= cnt_r + 4'h1;
        end
    end

    // receive shifter, first bit lands at the top
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            rx_r <= '0;
        end else if (scl_rise && rx_state) begin
            rx_r <= {rx_r[DATA_W-2:0], sda_s};
        end
    end

    // upper address byte: top three bits dropped
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            hi_r <= '0;
        end else if (byte_done && (state_r == ST_ADR_HI)) begin
            hi_r <= rx_r[HI_W-1:0];
        end
    end

    // address latch: loaded by the write header, stepped per stored or read data byte
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            addr_r <= ADDR_BASE;
        end else if (byte_done && (state_r == ST_ADR_LO)) begin
            addr_r <= {hi_r, rx_r};
        end else if (wr_commit) begin
            addr_r <= addr_inc(addr_r);
        end else if (byte_done && (state_r == ST_RDATA)) begin
            addr_r <= addr_inc(addr_r);
        end
    end
    // transmit shifter
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            tx_r <= '0;
        end else if (rd_load) begin
            tx_r <= {mem_port.rdata[DATA_W-2:0], 1'b0};
        end else if (scl_fall && (state_r == ST_RDATA)) begin
            tx_r <= {tx_r[DATA_W-2:0], 1'b0};
        end
    end

    // data line drive, changed only while SCL is low
    always_comb begin
        oe_nxt = 1'b0;
        unique case (state_nxt)
            ST_ACK_DEV,
            ST_ACK_HI,
            ST_ACK_LO,
            ST_ACK_WR: begin
                oe_nxt = 1'b1;
            end
            ST_RDATA: begin
                if (rd_load) begin
                    oe_nxt = ~mem_port.rdata[DATA_W-1];
                end else begin
                    oe_nxt = ~tx_r[DATA_W-1];
                end
            end
            default: begin
                oe_nxt = 1'b0;
            end
        endcase
    end

    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            oe_r <= 1'b0;
        end else if (bus_start || bus_stop) begin
            oe_r <= 1'b0;
        end else if (scl_fall) begin
            oe_r <= oe_nxt;
        end else if (state_nxt == ST_IDLE) begin
            oe_r <= 1'b0;
        end
    end

    // memory port
    assign mem_port.wr_en = wr_commit;
    assign mem_port.addr  = addr_r;
    assign mem_port.wdata = rx_r;

    // pins and status
    assign SDA_DRV      = SDA_LOW;
    assign SDA_OE       = oe_r;
    assign ADDR_CURRENT = addr_r;
    assign BUSY         = (state_r != ST_IDLE);

endmodule // ism_top

/* File: test/ism_monitor.sv */
// port checker for the two-wire memory target
// assumes it is bound to ism_top and sees only its ports
`timescale 1ns/1ps
module ism_monitor
    import ism_pkg::*;
(
    // clock and reset
    input wire logic              CLK_SYS,
    input wire logic              RESET,
    // bus and straps
    input wire logic              SCL,
    input wire logic              SDA,
    input wire logic              SDA_DRV,
    input wire logic              SDA_OE,
    input wire logic              WP,
    input wire logic [2:0]        SELECT_ADDRESS_INPUTS,
    // status
    input wire logic [ADDR_W-1:0] ADDR_CURRENT,
    input wire logic              BUSY
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (RESET);

    drive_low_a: assert property (SDA_DRV == SDA_LOW)
        else $error("data drive not low");
    reset_idle_a: assert property (
        $fell(RESET) |-> !SDA_OE && !BUSY && ADDR_CURRENT == ADDR_BASE)
        else $error("not idle after reset");
    oe_rise_low_a: assert property ($rose(SDA_OE) |-> !$past(SCL, 2))
        else $error("drive started outside clock low");
    addr_step_a: assert property ($changed(ADDR_CURRENT) |-> !$past(SCL, 2))
        else $error("address moved outside clock low");
    start_busy_a: assert property (SCL && $fell(SDA) |-> ##[1:5] BUSY)
        else $error("start not taken");
    stop_idle_a: assert property (SCL && $rose(SDA) |-> ##[1:5] !BUSY)
        else $error("stop did not idle");
    idle_release_a: assert property (!BUSY && !$past(BUSY) |-> !SDA_OE)
        else $error("drive while idle");
    oe_stands_a: assert property ($changed(SDA_OE) |=> $stable(SDA_OE) [*2])
        else $error("drive glitch");
    high_hold_a: assert property ($rose(SCL) |=> $stable(SDA_OE) [*3])
        else $error("drive moved in clock high");

    cover property ($past(ADDR_CURRENT) == ADDR_TOP && ADDR_CURRENT == ADDR_BASE);
    cover property (WP && $fell(BUSY));
    cover property (SELECT_ADDRESS_INPUTS == 3'h7 && $rose(SDA_OE));
endmodule // ism_monitor

bind ism_top ism_monitor i_mon (
    .CLK_SYS(CLK_SYS), .RESET(RESET), .SCL(SCL), .SDA(SDA),
    .SDA_DRV(SDA_DRV), .SDA_OE(SDA_OE), .WP(WP),
    .SELECT_ADDRESS_INPUTS(SELECT_ADDRESS_INPUTS),
    .ADDR_CURRENT(ADDR_CURRENT), .BUSY(BUSY)
);

/* File: test/ism_bus_ctrl.sv */
// two-wire bus controller model: start, stop and byte transfers
// assumes the bench resolves the open-drain data wire with a pull-up,
// and every line change lands on a rising system clock edge
`timescale 1ns/1ps
module ism_bus_ctrl (
    // system clock
    input  wire logic clk,
    // bus lines
    output logic      scl,
    output logic      sda_pull,
    input  wire logic sda
);
    // a quarter of the 80 ns bus clock, in system clocks
    localparam int QTR = 2;

    initial begin
        scl      = 1'b1;
        sda_pull = 1'b0;
    end

    task automatic tick();
        repeat (QTR) @(posedge clk);
    endtask

    // start or repeated start: data falls while clock high
    task automatic start();
        tick();
        sda_pull <= 1'b0;
        tick();
        scl <= 1'b1;
        tick();
        sda_pull <= 1'b1;
        tick();
        scl <= 1'b0;
    endtask

    // stop: data rises while clock high, clock then stands high
    task automatic stop();
        tick();
        sda_pull <= 1'b1;
        tick();
        scl <= 1'b1;
        tick();
        sda_pull <= 1'b0;
        tick();
    endtask

    // one clock: data set while low, wire sampled mid-high
    task automatic bit_x(input logic b, output logic s);
        tick();
        sda_pull <= !b;
        tick();
        scl <= 1'b1;
        tick();
        s = sda;
        tick();
        scl <= 1'b0;
    endtask

    // byte out msb first, then the acknowledge clock
    task automatic wr(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_x(d[i], s);
        end
        bit_x(1'b1, s);
        ack = !s;
    endtask

    // byte in msb first; ack asks for more, nack ends the read
    task automatic rd(input logic ack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_x(1'b1, s);
            d[i] = s;
        end
        bit_x(!ack, s);
    endtask
endmodule // ism_bus_ctrl

/* File: test/testbench.sv */
// self-checking bench for the two-wire memory target
// assumes ism_bus_ctrl plays the bus controller
`timescale 1ns/1ps
module testbench;
    import ism_pkg::*;
    localparam logic [2:0] SEL_V = 3'h5;
    logic              clk_sys;
    logic              reset;
    logic              wp;
    logic [2:0]        sel;
    logic              sda_oe;
    logic              sda_o;
    logic              busy;
    logic [ADDR_W-1:0] addr_cur;
    logic              scl;
    logic              pull;
    logic              sda;
    logic              a;
    logic [7:0]        d;
    int                bad_count;
    int                num_checks;

    assign sda = ((sda_oe && !sda_o) || pull) ? 1'b0 : 1'b1;

    ism_top i_dut (.CLK_SYS(clk_sys), .RESET(reset), .SCL(scl), .SDA(sda),
        .SDA_DRV(sda_o), .SDA_OE(sda_oe), .WP(wp), .SELECT_ADDRESS_INPUTS(sel),
        .ADDR_CURRENT(addr_cur), .BUSY(busy));
    ism_bus_ctrl i_ctl (.clk(clk_sys), .scl(scl), .sda_pull(pull), .sda(sda));

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = !clk_sys;
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic final_report();
        if (bad_count == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic set_in(input logic w, input logic [2:0] s);
        @(posedge clk_sys);
        wp  <= w;
        sel <= s;
        #3;
    endtask

    task automatic hdr(input logic [2:0] s, input logic dir, output logic ack);
        i_ctl.start();
        i_ctl.wr({DEV_TYPE, s, dir}, ack);
    endtask

    // top three address bits sent as ones
    task automatic set_addr(input logic [ADDR_W-1:0] ad);
        logic k;
        hdr(SEL_V, 1'b0, k);
        chk(k, 1'b1);
        i_ctl.wr({3'h7, ad[12:8]}, k);
        chk(k, 1'b1);
        i_ctl.wr(ad[7:0], k);
        chk(k, 1'b1);
    endtask

    task automatic wr_data(input logic [7:0] v, input logic exp_ack);
        logic k;
        i_ctl.wr(v, k);
        chk(k, exp_ack);
    endtask

    task automatic rd_chk(input logic ack, input logic [7:0] exp);
        logic [7:0] v;
        i_ctl.rd(ack, v);
        chk(v, exp);
    endtask

    task automatic stop_idle();
        int n;
        i_ctl.stop();
        #1;
        n = 0;
        while (busy !== 1'b0 && n < 20) begin
            #10;
            n++;
        end
        chk(busy, 1'b0);
        chk(sda_oe, 1'b0);
        if (n == 20) begin
            final_report();
        end
    endtask

    initial begin
        bad_count  = 0;
        num_checks = 0;
        reset      = 1'b1;
        wp         = 1'b0;
        sel        = SEL_V;
        repeat (20) @(posedge clk_sys);
        reset <= 1'b0;
        repeat (4) @(posedge clk_sys);
        #3;
        // burst write over the top address
        set_addr(ADDR_TOP - ADDR_ONE);
        wr_data(8'h11, 1'b1);
        wr_data(8'h22, 1'b1);
        chk(addr_cur, ADDR_BASE);
        wr_data(8'h33, 1'b1);
        stop_idle();
        chk(addr_cur, ADDR_ONE);
        // random read straight after the write, ended by stop in 9th clock
        set_addr(ADDR_TOP - ADDR_ONE);
        hdr(SEL_V, DIR_READ, a);
        chk(a, 1'b1);
        rd_chk(1'b1, 8'h11);
        rd_chk(1'b1, 8'h22);
        for (int i = 7; i >= 0; i--) begin
            i_ctl.bit_x(1'b1, d[i]);
        end
        chk(d, 8'h33);
        stop_idle();
        // current address reads keep the latch between transactions
        set_addr(ADDR_ONE);
        wr_data(8'h44, 1'b1);
        set_addr(ADDR_BASE);
        stop_idle();
        hdr(SEL_V, DIR_READ, a);
        rd_chk(1'b0, 8'h33);
        stop_idle();
        hdr(SEL_V, DIR_READ, a);
        rd_chk(1'b0, 8'h44);
        i_ctl.start();
        stop_idle();
        // write protect refuses the byte and holds the address
        set_addr(13'h0010);
        wr_data(8'h3c, 1'b1);
        set_in(1'b1, SEL_V);
        set_addr(13'h0010);
        wr_data(8'ha5, 1'b0);
        chk(addr_cur, 13'h0010);
        stop_idle();
        set_in(1'b0, SEL_V);
        // partial byte cut by a start is dropped
        set_addr(13'h0010);
        for (int i = 0; i < 7; i++) begin
            i_ctl.bit_x(1'b0, a);
        end
        hdr(SEL_V, DIR_READ, a);
        rd_chk(1'b0, 8'h3c);
        stop_idle();
        // every select strap value, matching and not
        for (int i = 0; i < 8; i++) begin
            set_in(1'b0, 3'(i));
            hdr(3'(i), 1'b0, a);
            chk(a, 1'b1);
            hdr(3'(i ^ 1), 1'b0, a);
            chk(a, 1'b0);
            stop_idle();
        end
        i_ctl.start();
        i_ctl.wr({~DEV_TYPE, 3'h7, 1'b0}, a);
        chk(a, 1'b0);
        stop_idle();
        final_report();
    end
endmodule // testbench
